// ===== bench/tb.sv
// testbench for the break matcher
`timescale 1ns/1ps
module tb import ubm_pkg::*;;
  typedef struct packed {
    logic [7:0] sel; logic [31:0] ba; logic [31:0] ca;
    logic [2:0] pfw; logic [1:0] sz; logic [2:0] pod; logic ex;
  } ubm_row_t;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, insn_done, addr_err_busy;
  logic hi_exc_accept, break_ack, break_req, break_take, ack_en, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, break_pc, rd;
  logic [3:0] cpu_mask, break_level, dly;
  ubm_cycle_t bus_cycle;
  int failures, samples_checked;
  ubm_row_t rows[15] = '{
    '{8'h6A, 32'h00123456, 32'h00123456, 3'b001, 2'h2, 3'h0, 1},
    '{8'h6A, 32'h00123456, 32'h00123456, 3'b001, 2'h1, 3'h0, 0},
    '{8'h54, 32'h00000404, 32'h00000404, 3'b010, 2'h2, 3'h0, 1},
    '{8'h58, 32'h0015389C, 32'h0015389C, 3'b010, 2'h2, 3'h0, 0},
    '{8'h54, 32'h00030147, 32'h00030147, 3'b010, 2'h2, 3'h0, 0},
    '{8'h66, 32'h00A80391, 32'h00A80391, 3'b000, 2'h2, 3'h0, 0},
    '{8'hA7, 32'h0076BCDC, 32'h0076BCDC, 3'b100, 2'h3, 3'h0, 1},
    '{8'h94, 32'h002345C8, 32'h002345C8, 3'b110, 2'h2, 3'h0, 0},
    '{8'h54, 32'h00000404, 32'h00000404, 3'b010, 2'h2, 3'h2, 0},
    '{8'h74, 32'h00000404, 32'h00000404, 3'b010, 2'h2, 3'h2, 1},
    '{8'h54, 32'h00000404, 32'h00000404, 3'b010, 2'h2, 3'h1, 0},
    '{8'h14, 32'h00000404, 32'h00000404, 3'b010, 2'h2, 3'h0, 0},
    '{8'h65, 32'h00A80391, 32'h00A80391, 3'b000, 2'h1, 3'h0, 1},
    '{8'h67, 32'h0076BCDC, 32'h0076BCDC, 3'b000, 2'h3, 3'h0, 1},
    '{8'h54, 32'h00000406, 32'h00000404, 3'b010, 2'h2, 3'h4, 1}};
  ubm_matcher dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_cycle(bus_cycle), .cpu_mask(cpu_mask), .insn_done(insn_done),
    .addr_err_busy(addr_err_busy), .hi_exc_accept(hi_exc_accept), .break_ack(break_ack),
    .break_req(break_req), .break_level(break_level), .break_take(break_take),
    .break_pc(break_pc));
  ubm_cpu_model cpu (.clock(clock), .rstn(rstn), .ack_en(ack_en), .dly(dly),
    .break_take(break_take), .break_ack(break_ack));
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task prog(input logic [7:0] sel, input logic [31:0] ba);
    apb(1, UBM_ADDR_HIGH, {16'h0, ba[31:16]});
    apb(1, UBM_ADDR_LOW, {16'h0, ba[15:0]});
    apb(1, UBM_CYC_SEL, {24'h0, sel});
  endtask
  task cyc(input logic [31:0] a, input logic [2:0] pfw, input logic [1:0] sz, input logic [2:0] pod);
    @(posedge clock);
    bus_cycle <= {1'b1, a, pfw, sz, pod};
    @(posedge clock);
    bus_cycle <= '0;
  endtask
  task fin(input logic ae, input logic ex);
    @(posedge clock);
    insn_done <= 1'b1; addr_err_busy <= ae;
    @(posedge clock);
    insn_done <= 1'b0; addr_err_busy <= 1'b0;
    repeat (2) @(negedge clock);
    chk(break_req, ex);
  endtask
  task clr;
    @(posedge clock);
    ack_en <= 1'b1;
    repeat (12) @(posedge clock);
    ack_en <= 1'b0;
  endtask
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    summarize;
  end
  initial begin
    {rstn, psel, penable, pwrite, insn_done, addr_err_busy, hi_exc_accept, ack_en} = '0;
    paddr = '0; pwdata = '0; cpu_mask = '0; dly = '0; bus_cycle = '0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    // ******************************
    // table of break conditions
    // ******************************
    foreach (rows[i]) begin
      prog(rows[i].sel, rows[i].ba);
      cyc(rows[i].ca, rows[i].pfw, rows[i].sz, rows[i].pod);
      fin(0, rows[i].ex);
      if (rows[i].ex && rows[i].pfw[1] && !rows[i].pod[1]) chk(break_pc, rows[i].ba);
      clr;
    end
    // ******************************
    // awkward cases
    // ******************************
    prog(8'h54, 32'h00000406);
    cyc(32'h00000404, 3'b010, 2'h2, 3'h4);
    apb(1, UBM_CYC_SEL, 0);
    fin(0, 1);
    clr;
    prog(8'h54, 32'h00000404);
    cyc(32'h00000404, 3'b010, 2'h2, 3'h0);
    fin(1, 0);
    apb(0, UBM_STATUS, 0);
    chk(rd[1], 1);
    insn_done <= 1'b1;
    @(posedge clock);
    insn_done <= 1'b0;
    repeat (2) @(negedge clock);
    chk(break_req, 1);
    clr;
    cyc(32'h00000404, 3'b010, 2'h2, 3'h0);
    hi_exc_accept <= 1'b1;
    @(posedge clock);
    hi_exc_accept <= 1'b0;
    fin(0, 0);
    prog(8'h6A, 32'h00123456);
    cpu_mask <= 4'hF;
    cyc(32'h00123456, 3'b001, 2'h2, 3'h0);
    fin(0, 1);
    chk(break_take, 0);
    apb(0, UBM_STATUS, 0);
    chk(rd[0], 1);
    cpu_mask <= 4'hE;
    dly <= 4'h5;
    @(negedge clock);
    chk(break_take, 1);
    clr;
    chk(break_req, 0);
    apb(0, 12'h018, 0);
    chk(rd, 0);
    chk(er, 1);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    apb(0, UBM_ADDR_LOW, 0);
    chk(rd, 0);
    apb(0, UBM_CYC_SEL, 0);
    chk(rd, 0);
    summarize;
  end
endmodule

// ===== bench/ubm_cpu_model.sv
// cpu side model: enters break processing once the request is acceptable
`timescale 1ns/1ps
module ubm_cpu_model (
  input wire logic clock, // system clock
  input wire logic rstn, // reset, active low
  input wire logic ack_en, // cpu free to enter break processing
  input wire logic [3:0] dly, // extra cycles before entering
  input wire logic break_take, // request acceptable at current mask
  output logic break_ack // entered break processing
);
  logic [3:0] cnt_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
      break_ack <= 1'b0;
    end else if (ack_en && break_take && !break_ack && cnt_r >= dly) begin
      cnt_r <= 4'h0;
      break_ack <= 1'b1;
    end else begin
      cnt_r <= (ack_en && break_take && !break_ack) ? cnt_r + 4'h1 : 4'h0;
      break_ack <= 1'b0;
    end
  end
endmodule

// ===== bench/ubm_matcher_monitor.sv
// checker for the break request outputs and the register port
`timescale 1ns/1ps
module ubm_monitor
  import ubm_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rstn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pslverr, // apb error
  input wire ubm_cycle_t bus_cycle, // observed bus cycle
  input wire logic [3:0] cpu_mask, // cpu mask level
  input wire logic insn_done, // instruction completed
  input wire logic addr_err_busy, // address error in progress
  input wire logic hi_exc_accept, // higher priority exception
  input wire logic break_ack, // break entered
  input wire logic break_req, // break request
  input wire logic [3:0] break_level, // request level
  input wire logic break_take // request acceptable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_stat_rd(int b);
    psel && penable && !pwrite && paddr == UBM_STATUS && prdata[b] && !break_ack;
  endsequence
  sequence s_go;
    insn_done && !addr_err_busy && !hi_exc_accept;
  endsequence
  a_level_fixed: assert property (break_level == 4'hF)
    else $error("break level not fifteen");
  a_take_mask: assert property (break_take == (break_req && cpu_mask <= 4'hE))
    else $error("break take disagrees with mask");
  a_ack_clears: assert property (break_ack |=> !break_req)
    else $error("request kept after ack");
  a_req_hold: assert property (break_req && !break_ack && !hi_exc_accept |=> break_req)
    else $error("request dropped while pending");
  a_rise_cause: assert property ($rose(break_req) |->
    $past(bus_cycle.valid, 2) || ($past(insn_done) && !$past(addr_err_busy)))
    else $error("request rose without a cause");
  a_data_pend: assert property (s_stat_rd(0) |=> break_req)
    else $error("data pending without request");
  a_fetch_go: assert property (s_stat_rd(1) ##1 s_go |=> break_req)
    else $error("fetch pending not raised after completion");
  a_unmapped_err: assert property (psel && penable && paddr == 12'h018 |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
endmodule
bind ubm_matcher ubm_monitor mon (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .bus_cycle, .cpu_mask, .insn_done, .addr_err_busy, .hi_exc_accept, .break_ack,
  .break_req, .break_level, .break_take);

// ===== design/ubm_matcher.sv
// user break matcher: compares every bus cycle against the programmed break condition
// How it works
// [R1] compare address is high half above low half
// [R2] select values 0x54, 0x6A, 0xA7 decode as fetch, word write, periph long read
// [R3] fetch match raises break before the matching instruction executes
// [R4] fetch break waits until the preceding interruptible instruction completes
// [R5] return pc for a fetch break is the matching address
// [R6] fetch combined with write never breaks
// [R7] fetch break on odd address never matches
// [R8] odd branch target match breaks after address error exception
// [R9] cpu word write at programmed address breaks
// [R10] word data break on odd address never matches
// [R11] dma/dtc longword read at programmed address breaks
// [R12] peripheral instruction fetch condition never matches
// [R13] paired fetch second match holds even if condition changes
// [R14] taken branch or trap makes overrun fetches before destination
// [R15] overrun fetches are not fetch break matches
// [R16] overrun fetch matches when data access breaks are also enabled
// [R17] pending break may drop after higher priority exception returns
// [R18] software avoids fetch breaks on branch destination instructions
// [R19] first destination fetch of non-delayed branch never breaks
// [R20] group 01 first kind, 10 second, 11 both, 00 no break
// [R21] size 00 any, 01 byte, 10 word, 11 longword
// [R22] request at level 15, taken only when cpu mask is 14 or lower
// [R23] all enabled conditions must agree on the same bus cycle
`timescale 1ns/1ps
module ubm_matcher
  import ubm_pkg::*;
(
  input wire logic clock,               // system clock, 100 MHz
  input wire logic rstn,                // asynchronous reset, active low
  input wire logic psel,                // apb select
  input wire logic penable,             // apb access phase
  input wire logic pwrite,              // apb direction
  input wire logic [11:0] paddr,        // apb byte address
  input wire logic [31:0] pwdata,       // apb write data
  output logic [31:0] prdata,           // apb read data
  output logic pready,                  // apb ready
  output logic pslverr,                 // apb error on unmapped address
  input wire ubm_cycle_t bus_cycle,     // observed bus cycle
  input wire logic [3:0] cpu_mask,      // cpu interrupt mask level
  input wire logic insn_done,           // current instruction completed and can accept
  input wire logic addr_err_busy,       // address error exception in progress
  input wire logic hi_exc_accept,       // higher priority exception accepted in decode
  input wire logic break_ack,           // cpu entered break exception processing
  output logic break_req,               // break request to interrupt controller
  output logic [3:0] break_level,       // priority level of the request
  output logic break_take,              // request acceptable at current mask
  output logic [31:0] break_pc          // pc to save for a fetch break
);

  // ******************************
  // register file
  // ******************************
  logic [15:0] addr_high_r;
  logic [15:0] addr_low_r;
  logic [15:0] mask_high_r;
  logic [15:0] mask_low_r;
  logic [7:0] cycle_sel_r;
  logic fetch_pend_r;
  logic data_pend_r;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_word;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  // ******************************
  // read mux
  // ******************************
  // unused upper bits read as zero; an unmapped offset reads zero and is refused
  always_comb begin
    mapped = 1'b1;
    rd_word = UBM_WORD_ZERO;
    case (paddr)
      UBM_ADDR_HIGH: rd_word = {16'h0000, addr_high_r};
      UBM_ADDR_LOW: rd_word = {16'h0000, addr_low_r};
      UBM_MASK_HIGH: rd_word = {16'h0000, mask_high_r};
      UBM_MASK_LOW: rd_word = {16'h0000, mask_low_r};
      UBM_CYC_SEL: rd_word = {24'h000000, cycle_sel_r};
      UBM_STATUS: rd_word = {30'h0, fetch_pend_r, data_pend_r};
      default: mapped = 1'b0;
    endcase
  end

  // word captured in the setup cycle, so it stands from a flip-flop through the access phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= UBM_WORD_ZERO;
    end else if (psel && !penable) begin
      prdata <= rd_word;
    end
  end

  assign pslverr = psel && penable && !mapped;

  // ******************************
  // write path
  // ******************************

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_high_r <= UBM_HALF_RST;
      addr_low_r <= UBM_HALF_RST;
      mask_high_r <= UBM_HALF_RST;
      mask_low_r <= UBM_HALF_RST;
      cycle_sel_r <= UBM_SEL_RST;
    end else if (wr_en) begin
      case (paddr)
        UBM_ADDR_HIGH: addr_high_r <= pwdata[15:0];
        UBM_ADDR_LOW: addr_low_r <= pwdata[15:0];
        UBM_MASK_HIGH: mask_high_r <= pwdata[15:0];
        UBM_MASK_LOW: mask_low_r <= pwdata[15:0];
        UBM_CYC_SEL: cycle_sel_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ******************************
  // condition decode
  // ******************************
  logic [31:0] brk_addr;
  logic [31:0] brk_mask;
  logic [1:0] src_sel;
  logic [1:0] kind_sel;
  logic [1:0] dir_sel;
  logic [1:0] size_sel;

  assign brk_addr = {addr_high_r, addr_low_r}; // R1
  assign brk_mask = {mask_high_r, mask_low_r};
  assign src_sel = cycle_sel_r[UBM_SRC_LSB +: 2]; // R2
  assign kind_sel = cycle_sel_r[UBM_KIND_LSB +: 2]; // R2
  assign dir_sel = cycle_sel_r[UBM_DIR_LSB +: 2]; // R2
  assign size_sel = cycle_sel_r[UBM_SIZE_LSB +: 2]; // R2

  // ******************************
  // elaboration checks
  // ******************************
  // the four select groups must tile the select register from the top down
  if (UBM_SRC_LSB + UBM_GRP_W != UBM_SEL_W || UBM_KIND_LSB + UBM_GRP_W != UBM_SRC_LSB ||
      UBM_DIR_LSB + UBM_GRP_W != UBM_KIND_LSB ||
      UBM_SIZE_LSB + UBM_GRP_W != UBM_DIR_LSB) begin : g_bad_fields
    $error("break select fields do not tile the select register");
  end

  // the two address halves must make up the whole compare address
  if (UBM_HALF_W + UBM_HALF_W != UBM_ADDR_W) begin : g_bad_halves
    $error("break address halves do not make up the compare address");
  end

  // group test: 01 accepts the first kind, 10 the second, 11 both, 00 nothing
  function automatic logic grp_hit(input logic [1:0] sel, input logic second);
    logic hit;
    hit = 1'b0;
    case (sel)
      UBM_GRP_NONE: hit = 1'b0; // R20
      UBM_GRP_FIRST: hit = !second; // R20
      UBM_GRP_SECOND: hit = second; // R20
      UBM_GRP_BOTH: hit = 1'b1; // R20
      default: hit = 1'b0;
    endcase
    grp_hit = hit;
  endfunction

  function automatic logic size_hit(input logic [1:0] sel, input logic [1:0] sz);
    logic hit;
    hit = 1'b0;
    case (sel)
      UBM_SZ_ANY: hit = 1'b1; // R21
      UBM_SZ_BYTE: hit = (sz == UBM_SZ_BYTE); // R21
      UBM_SZ_WORD: hit = (sz == UBM_SZ_WORD); // R21
      UBM_SZ_LONG: hit = (sz == UBM_SZ_LONG); // R21
      default: hit = 1'b0;
    endcase
    size_hit = hit;
  endfunction

  // ******************************
  // cycle match
  // ******************************
  logic addr_hit;
  logic addr_hit_hi;
  logic src_ok;
  logic dir_ok;
  logic size_ok;
  logic fetch_kind_ok;
  logic data_kind_ok;
  logic fetch_match;
  logic data_match;
  logic align_ok;
  logic cyc_size_word;

  // ******************************
  // observed cycle fields
  // ******************************
  logic [31:0] cyc_addr;
  logic cyc_periph;
  logic cyc_fetch;
  logic cyc_write;
  logic cyc_pair;
  logic cyc_overrun;
  logic cyc_dest_first;

  assign cyc_addr = bus_cycle.addr;
  assign cyc_periph = bus_cycle.periph;
  assign cyc_fetch = bus_cycle.fetch;
  assign cyc_write = bus_cycle.write;
  assign cyc_pair = bus_cycle.pair;
  assign cyc_overrun = bus_cycle.overrun;
  assign cyc_dest_first = bus_cycle.dest_first;

  // ******************************
  // address compare
  // ******************************
  // a paired on-chip fetch carries two instructions; the second sits one step higher
  // a set mask bit takes that bit out of the compare
  logic [31:0] addr_plus;
  logic [31:0] bit_hit_lo;
  logic [31:0] bit_hit_hi;

  assign addr_plus = cyc_addr + UBM_PAIR_STEP;
  for (genvar gi = 0; gi < UBM_ADDR_W; gi++) begin : g_addr_bit
    assign bit_hit_lo[gi] = brk_mask[gi] || (cyc_addr[gi] == brk_addr[gi]); // R1
    assign bit_hit_hi[gi] = brk_mask[gi] || (addr_plus[gi] == brk_addr[gi]); // R13
  end
  assign addr_hit = &bit_hit_lo;
  assign addr_hit_hi = cyc_pair && cyc_fetch && (&bit_hit_hi); // R13

  assign src_ok = grp_hit(src_sel, bus_cycle.periph);
  assign dir_ok = grp_hit(dir_sel, bus_cycle.write);
  assign cyc_size_word = bus_cycle.fetch;
  // fetches count as word size regardless of bus width
  assign size_ok = size_hit(size_sel, cyc_size_word ? UBM_SZ_WORD : bus_cycle.size);

  // word and longword accesses never carry odd addresses
  assign align_ok = (size_sel == UBM_SZ_BYTE) || !brk_addr[0]; // R7 R10

  // a fetch is only a fetch match when it will really execute
  logic fetch_refused;
  always_comb begin
    fetch_refused = 1'b0;
    if (cyc_periph) begin
      fetch_refused = 1'b1; // R12
    end
    if (cyc_overrun) begin
      fetch_refused = 1'b1; // R14 R15
    end
    if (cyc_dest_first) begin
      fetch_refused = 1'b1; // R19
    end
    if (cyc_write) begin
      fetch_refused = 1'b1; // R6
    end
  end
  assign fetch_kind_ok = kind_sel[0] && !fetch_refused;
  // an overrun fetch is judged as a data access when data breaks are on too
  assign data_kind_ok = kind_sel[1] && (!bus_cycle.fetch || bus_cycle.overrun); // R16

  always_comb begin
    fetch_match = 1'b0;
    data_match = 1'b0;
    if (bus_cycle.valid && src_ok && dir_ok && size_ok && align_ok) begin // R23
      if (bus_cycle.fetch && fetch_kind_ok && (addr_hit || addr_hit_hi)) begin
        fetch_match = 1'b1; // R3 R13
      end
      if (data_kind_ok && addr_hit) begin
        data_match = 1'b1; // R9 R11 R16
      end
    end
  end

  // ******************************
  // pending break
  // ******************************
  logic [31:0] break_pc_r;
  logic pair_hold_r;
  logic [31:0] pair_pc_r;

  // ******************************
  // pair hold
  // ******************************
  // second instruction of a pair: matched at fetch, held even if registers change
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pair_hold_r <= 1'b0;
      pair_pc_r <= 32'h0000_0000;
    end else if (fetch_match && addr_hit_hi && !addr_hit) begin
      pair_hold_r <= 1'b1; // R13
      pair_pc_r <= addr_plus;
    end else if (pair_hold_r && insn_done) begin
      pair_hold_r <= 1'b0; // R13
    end
  end

  // ******************************
  // fetch pending
  // ******************************
  logic fetch_set_own;
  logic fetch_set_pair;
  logic fetch_drop;

  assign fetch_set_own = fetch_match && addr_hit; // R3
  assign fetch_set_pair = pair_hold_r && insn_done; // R13
  assign fetch_drop = break_ack || hi_exc_accept; // R17

  // set wins over clear so a match in the ack cycle is not lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fetch_pend_r <= 1'b0;
      break_pc_r <= UBM_WORD_ZERO;
    end else if (fetch_set_own) begin
      fetch_pend_r <= 1'b1; // R3
      break_pc_r <= cyc_addr; // R5
    end else if (fetch_set_pair) begin
      fetch_pend_r <= 1'b1; // R13
      break_pc_r <= pair_pc_r; // R5
    end else if (fetch_drop) begin
      fetch_pend_r <= 1'b0; // R17
    end
  end

  // ******************************
  // data pending
  // ******************************
  // data breaks wait for no completion; the request follows one cycle after the pending flag, two after the match
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_pend_r <= 1'b0;
    end else if (data_match) begin
      data_pend_r <= 1'b1; // R11
    end else if (break_ack) begin
      data_pend_r <= 1'b0;
    end
  end

  // ******************************
  // request to interrupt controller
  // ******************************
  logic req_r;
  logic fetch_go;

  // a held second-of-pair break is raised by the completion that ends the first
  assign fetch_go = fetch_pend_r || pair_hold_r; // R13

  // fetch breaks wait for the preceding instruction to finish and for any address error
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_r <= 1'b0;
    end else if (break_ack) begin
      req_r <= 1'b0;
    end else if (data_pend_r || (fetch_go && insn_done && !addr_err_busy)) begin
      req_r <= 1'b1; // R4 R8 R13
    end else if (!fetch_pend_r && !data_pend_r) begin
      req_r <= 1'b0; // R17
    end
  end

  assign break_req = req_r;
  assign break_level = UBM_BREAK_LEVEL; // R22
  assign break_take = req_r && (cpu_mask < UBM_BREAK_LEVEL); // R22
  assign break_pc = break_pc_r;

endmodule

// ===== inc/ubm_pkg.sv
// package for the user break matcher: register map, fields, bus cycle carrier
package ubm_pkg;

  // ******************************
  // register map (byte addresses)
  // ******************************
  localparam logic [11:0] UBM_ADDR_HIGH = 12'h000;
  localparam logic [11:0] UBM_ADDR_LOW = 12'h004;
  localparam logic [11:0] UBM_MASK_HIGH = 12'h008;
  localparam logic [11:0] UBM_MASK_LOW = 12'h00C;
  localparam logic [11:0] UBM_CYC_SEL = 12'h010;
  localparam logic [11:0] UBM_STATUS = 12'h014;

  // ******************************
  // reset values and field layout
  // ******************************
  localparam logic [15:0] UBM_HALF_RST = 16'h0000;
  localparam logic [7:0] UBM_SEL_RST = 8'h00;
  localparam int UBM_SRC_LSB = 6;
  localparam int UBM_KIND_LSB = 4;
  localparam int UBM_DIR_LSB = 2;
  localparam int UBM_SIZE_LSB = 0;
  localparam int UBM_HALF_W = 16;
  localparam int UBM_ADDR_W = 32;
  localparam int UBM_SEL_W = 8;
  localparam int UBM_GRP_W = 2;
  localparam logic [31:0] UBM_PAIR_STEP = 32'h0000_0002;
  localparam logic [31:0] UBM_WORD_ZERO = 32'h0000_0000;

  // two-bit group codes
  localparam logic [1:0] UBM_GRP_NONE = 2'h0;
  localparam logic [1:0] UBM_GRP_FIRST = 2'h1;
  localparam logic [1:0] UBM_GRP_SECOND = 2'h2;
  localparam logic [1:0] UBM_GRP_BOTH = 2'h3;

  // operand size codes
  localparam logic [1:0] UBM_SZ_ANY = 2'h0;
  localparam logic [1:0] UBM_SZ_BYTE = 2'h1;
  localparam logic [1:0] UBM_SZ_WORD = 2'h2;
  localparam logic [1:0] UBM_SZ_LONG = 2'h3;

  // break request priority level towards the interrupt controller
  localparam logic [3:0] UBM_BREAK_LEVEL = 4'hF;

  // one observed bus cycle
  typedef struct packed {
    logic valid;       // cycle present this clock
    logic [31:0] addr; // byte address
    logic periph;      // 1: dma/dtc cycle, 0: cpu cycle
    logic fetch;       // 1: instruction fetch, 0: data access
    logic write;       // 1: write, 0: read
    logic [1:0] size;  // UBM_SZ_BYTE/WORD/LONG
    logic pair;        // fetch returns two instructions (on-chip, 32-bit)
    logic overrun;     // fetch is an overrun fetch that will not execute
    logic dest_first;  // first destination fetch of a non-delayed branch
  } ubm_cycle_t;

endpackage
